// ### slfm_pkg.sv
// Constants, types and the input synchroniser of the strap latch and function mux
`default_nettype none

package slfm_pkg;
  localparam int NUM_PORTS = 4;
  localparam int NUM_PINS  = 30;
  localparam int FIRST_PIN = 2;
  localparam int LVL_W     = 3;
  localparam int CLS_W     = 4;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;

  // Strap levels as delivered by the level sensor
  localparam logic [2:0] LVL_WEAK_DOWN  = 3'h0;
  localparam logic [2:0] LVL_WEAK_UP    = 3'h1;
  localparam logic [2:0] LVL_MID_DOWN   = 3'h2;
  localparam logic [2:0] LVL_MID_UP     = 3'h3;
  localparam logic [2:0] LVL_STRONG_DN  = 3'h4;

  // Register offsets
  localparam logic [7:0] REG_STATUS     = 8'h00;
  localparam logic [7:0] REG_PORTS      = 8'h04;
  localparam logic [7:0] REG_OVR_EN     = 8'h08;
  localparam logic [7:0] REG_PINSEL_0   = 8'h80;

  // Field positions
  localparam int ST_SET_LSB   = 0;
  localparam int ST_RSVD_BIT  = 3;
  localparam int ST_CAPT_BIT  = 4;
  localparam int ST_INRST_BIT = 5;
  localparam int PT_DIS_LSB   = 0;
  localparam int PT_FIX_LSB   = 4;
  localparam int PT_CHG_LSB   = 8;
  localparam int PS_CLS_LSB   = 8;

  // Values after reset
  localparam logic [29:0] OVR_EN_RST  = 30'h0;
  localparam logic [2:0]  SET_RST     = 3'h0;
  localparam logic [3:0]  MASK_RST    = 4'h0;

  typedef enum logic [3:0] {
    SLFM_FN_GPIO,
    SLFM_FN_POWER_SERIAL,
    SLFM_FN_AUDIO,
    SLFM_FN_UART,
    SLFM_FN_POWER_TWOWIRE,
    SLFM_FN_MASTER_TWOWIRE,
    SLFM_FN_PORT_CTL,
    SLFM_FN_ALERT,
    SLFM_FN_SLAVE_TWOWIRE,
    SLFM_FN_FLASH_SERIAL,
    SLFM_FN_MIC_DETECT
  } slfm_func_t;

  // Level to thermometer port mask, reserved codes give no ports
  function automatic logic [3:0] slfm_lvl_mask(input logic [2:0] lvl);
    unique case (lvl)
      LVL_WEAK_DOWN: slfm_lvl_mask = 4'h0;
      LVL_WEAK_UP:   slfm_lvl_mask = 4'h1;
      LVL_MID_DOWN:  slfm_lvl_mask = 4'h3;
      LVL_MID_UP:    slfm_lvl_mask = 4'h7;
      LVL_STRONG_DN: slfm_lvl_mask = 4'hf;
      default:       slfm_lvl_mask = 4'h0;
    endcase
  endfunction
endpackage

module slfm_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

`default_nettype wire

// ### slfm_strap_mux.sv
// Strap capture, setting decode, pin function mux and register port
`default_nettype none

module slfm_strap_mux (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_b,
  input  wire logic                     por_active,
  input  wire logic                     ext_reset_b,
  input  wire logic [3:0]               dplus_port_disable_strap,
  input  wire logic [3:0]               dminus_port_disable_strap,
  input  wire logic [2:0]               fixed_device_strap,
  input  wire logic [2:0]               charging_ports_strap,
  input  wire logic [2:0]               function_set_strap1,
  input  wire logic [2:0]               function_set_strap2,
  input  wire logic [2:0]               function_set_strap3,
  input  wire logic [7:0]               addr,
  input  wire logic [31:0]              wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output var  logic [31:0]              rdata,
  output var  logic [3:0]               hs_port_disable,
  output var  logic [3:0]               ss_port_disable,
  output var  logic [3:0]               fixed_port_mask,
  output var  logic [3:0]               charging_port_mask,
  output var  logic [2:0]               function_set,
  output var  logic                     strap_reserved,
  output var  logic                     straps_captured,
  output var  logic [30*4-1:0]          multipurpose_pin_function
);
  localparam int SYNC_W = 2 + 8 + 4 * 3;

  typedef struct packed {
    logic             in_rst;
    logic             in_rst_d;
    logic [3:0]       samp_dp;
    logic [3:0]       samp_dm;
    logic [2:0]       samp_fix;
    logic [2:0]       samp_chg;
    logic [2:0]       samp_s1;
    logic [2:0]       samp_s2;
    logic [3:0]       hs_dis;
    logic [3:0]       ss_dis;
    logic [3:0]       fix_mask;
    logic [3:0]       chg_mask;
    logic [2:0]       fset;
    logic             rsvd;
    logic             capt;
    logic [29:0]      ovr_en;
    logic [29:0][2:0] ovr_col;
    logic [29:0][3:0] pin_fn;
    logic [31:0]      rdata;
  } slfm_state_t;

  slfm_state_t st_r;
  slfm_state_t st_nxt;

  logic [SYNC_W-1:0] sync_q;
  logic              por_s;
  logic              ext_b_s;
  logic [3:0]        dp_s;
  logic [3:0]        dm_s;
  logic [2:0]        fix_s;
  logic [2:0]        chg_s;
  logic [2:0]        s1_s;
  logic [2:0]        s2_s;
  logic              rst_now;
  logic              release_w;

  // Strap three is not synchronised: nothing reads it
  slfm_sync #(
    .W(SYNC_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_b  (rst_b),
    .d      ({por_active, ext_reset_b, dplus_port_disable_strap,
              dminus_port_disable_strap, fixed_device_strap,
              charging_ports_strap, function_set_strap1, function_set_strap2}),
    .q      (sync_q)
  );

  assign {por_s, ext_b_s, dp_s, dm_s, fix_s, chg_s, s1_s, s2_s} = sync_q;
  assign rst_now   = por_s | ~ext_b_s;
  assign release_w = st_r.in_rst_d & ~st_r.in_rst;

  // Function of one pin for one set column
  function automatic slfm_pkg::slfm_func_t pin_class(input int pin, input logic [2:0] col);
    slfm_pkg::slfm_func_t f;
    f = slfm_pkg::SLFM_FN_GPIO;
    if (pin == 2) begin
      if (col == 3'h2) f = slfm_pkg::SLFM_FN_UART;
    end else if (pin == 3) begin
      if (col == 3'h1) f = slfm_pkg::SLFM_FN_AUDIO;
      else if (col == 3'h2) f = slfm_pkg::SLFM_FN_UART;
    end else if (pin >= 4 && pin <= 7) begin
      if (col == 3'h0) f = slfm_pkg::SLFM_FN_POWER_SERIAL;
      else if (col == 3'h1) f = slfm_pkg::SLFM_FN_AUDIO;
      else if (col == 3'h2) f = slfm_pkg::SLFM_FN_UART;
    end else if (pin == 8 || pin == 9) begin
      f = (col == 3'h0) ? slfm_pkg::SLFM_FN_POWER_SERIAL
                        : slfm_pkg::SLFM_FN_POWER_TWOWIRE;
    end else if (pin == 10 || pin == 11) begin
      f = slfm_pkg::SLFM_FN_MASTER_TWOWIRE;
    end else if (pin == 12 || pin == 13 || pin == 16) begin
      f = slfm_pkg::SLFM_FN_PORT_CTL;
    end else if (pin == 15 || pin == 17 || pin == 18) begin
      f = slfm_pkg::SLFM_FN_ALERT;
    end else if (pin == 19 || pin == 26) begin
      if (col != 3'h3) f = slfm_pkg::SLFM_FN_SLAVE_TWOWIRE;
    end else if (pin >= 20 && pin <= 25) begin
      f = slfm_pkg::SLFM_FN_FLASH_SERIAL;
    end else if (pin == 27) begin
      if (col == 3'h1) f = slfm_pkg::SLFM_FN_MIC_DETECT;
    end else if (pin == 28) begin
      if (col == 3'h2) f = slfm_pkg::SLFM_FN_UART;
    end
    return f;
  endfunction

  always_comb begin
    logic [2:0]  col;
    logic [7:0]  off;
    logic [4:0]  idx;
    logic        ps_hit;
    st_nxt = st_r;
    col    = 3'h0;
    off    = addr - slfm_pkg::REG_PINSEL_0;
    idx    = off[6:2];
    ps_hit = (addr >= slfm_pkg::REG_PINSEL_0) && (off[1:0] == 2'h0)
             && (idx < 5'(slfm_pkg::NUM_PINS));

    // Reset tracking; samples follow the straps only while in reset
    st_nxt.in_rst   = rst_now;
    st_nxt.in_rst_d = st_r.in_rst;
    if (st_r.in_rst) begin
      st_nxt.samp_dp  = dp_s;
      st_nxt.samp_dm  = dm_s;
      st_nxt.samp_fix = fix_s;
      st_nxt.samp_chg = chg_s;
      st_nxt.samp_s1  = s1_s;
      st_nxt.samp_s2  = s2_s;
    end

    // Settings move only on the release edge, held otherwise
    if (release_w) begin
      st_nxt.hs_dis   = st_r.samp_dp & st_r.samp_dm;
      st_nxt.ss_dis   = st_r.samp_dp & st_r.samp_dm;
      st_nxt.fix_mask = slfm_pkg::slfm_lvl_mask(st_r.samp_fix);
      st_nxt.chg_mask = slfm_pkg::slfm_lvl_mask(st_r.samp_chg);
      st_nxt.capt     = 1'b1;
      // Illegal combinations fall back to set 1 and raise a flag
      if (st_r.samp_s2 == slfm_pkg::LVL_WEAK_DOWN
          && st_r.samp_s1 <= slfm_pkg::LVL_STRONG_DN) begin
        st_nxt.fset = st_r.samp_s1;
        st_nxt.rsvd = 1'b0;
      end else begin
        st_nxt.fset = slfm_pkg::SET_RST;
        st_nxt.rsvd = 1'b1;
      end
      if (st_r.samp_fix > slfm_pkg::LVL_STRONG_DN
          || st_r.samp_chg > slfm_pkg::LVL_STRONG_DN) begin
        st_nxt.rsvd = 1'b1;
      end
    end

    // Per-pin function, strap set unless overridden
    for (int i = 0; i < slfm_pkg::NUM_PINS; i++) begin
      col = st_r.ovr_en[i] ? st_r.ovr_col[i] : st_r.fset;
      st_nxt.pin_fn[i] = 4'(pin_class(i + slfm_pkg::FIRST_PIN, col));
    end

    // Register writes, accepted at any time
    if (wr) begin
      if (addr == slfm_pkg::REG_OVR_EN) begin
        st_nxt.ovr_en = wdata[29:0];
      end else if (ps_hit) begin
        st_nxt.ovr_col[idx] = wdata[2:0];
      end
    end

    // Read data stands only in the cycle after the strobe
    st_nxt.rdata = 32'h0;
    if (rd) begin
      if (addr == slfm_pkg::REG_STATUS) begin
        st_nxt.rdata[slfm_pkg::ST_SET_LSB +: 3]  = st_r.fset;
        st_nxt.rdata[slfm_pkg::ST_RSVD_BIT]      = st_r.rsvd;
        st_nxt.rdata[slfm_pkg::ST_CAPT_BIT]      = st_r.capt;
        st_nxt.rdata[slfm_pkg::ST_INRST_BIT]     = st_r.in_rst;
      end else if (addr == slfm_pkg::REG_PORTS) begin
        st_nxt.rdata[slfm_pkg::PT_DIS_LSB +: 4]  = st_r.hs_dis;
        st_nxt.rdata[slfm_pkg::PT_FIX_LSB +: 4]  = st_r.fix_mask;
        st_nxt.rdata[slfm_pkg::PT_CHG_LSB +: 4]  = st_r.chg_mask;
      end else if (addr == slfm_pkg::REG_OVR_EN) begin
        st_nxt.rdata[29:0] = st_r.ovr_en;
      end else if (ps_hit) begin
        st_nxt.rdata[2:0]  = st_r.ovr_col[idx];
        st_nxt.rdata[slfm_pkg::PS_CLS_LSB +: 4] = st_r.pin_fn[idx];
      end
    end
  end

  // Block reset starts in reset so the first release captures the straps
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r          <= '0;
      st_r.in_rst   <= 1'b1;
      st_r.in_rst_d <= 1'b1;
      st_r.ovr_en   <= slfm_pkg::OVR_EN_RST;
      st_r.fset     <= slfm_pkg::SET_RST;
      st_r.fix_mask <= slfm_pkg::MASK_RST;
      st_r.chg_mask <= slfm_pkg::MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata                     = st_r.rdata;
  assign hs_port_disable           = st_r.hs_dis;
  assign ss_port_disable           = st_r.ss_dis;
  assign fixed_port_mask           = st_r.fix_mask;
  assign charging_port_mask        = st_r.chg_mask;
  assign function_set              = st_r.fset;
  assign strap_reserved            = st_r.rsvd;
  assign straps_captured           = st_r.capt;
  assign multipurpose_pin_function = st_r.pin_fn;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence release_s;
    release_w ##1 1'b1;
  endsequence

  sequence hold_s;
    !release_w;
  endsequence

  hold_in_reset_a: assert property (hold_s |=> $stable(st_r.hs_dis) && $stable(st_r.fset))
    else $error("settings changed outside release");

  port_disable_a: assert property (release_s |-> hs_port_disable ==
      ($past(st_r.samp_dp) & $past(st_r.samp_dm)))
    else $error("port disable not and of both straps");

  ss_follow_a: assert property (release_w |=> ss_port_disable == hs_port_disable)
    else $error("superspeed disable differs");

  fixed_mask_a: assert property (release_w && st_r.samp_fix == 3'h2
      |=> fixed_port_mask == 4'h3)
    else $error("fixed mask decode wrong");

  charging_a: assert property (release_w && st_r.samp_chg == 3'h4
      |=> charging_port_mask == 4'hf)
    else $error("charging mask decode wrong");

  set_select_a: assert property (release_w && st_r.samp_s2 == 3'h0
      && st_r.samp_s1 == 3'h2 |=> function_set == 3'h2 && !strap_reserved)
    else $error("set selection wrong");

  reserved_set_a: assert property (release_w && st_r.samp_s2 != 3'h0
      |=> strap_reserved && function_set == 3'h0)
    else $error("reserved set not flagged");

  set1_route_a: assert property (function_set == 3'h0 && !st_r.ovr_en[2]
      |=> multipurpose_pin_function[8 +: 4] == 4'(slfm_pkg::SLFM_FN_POWER_SERIAL))
    else $error("set one routing wrong");

  override_a: assert property (st_r.ovr_en[2] && st_r.ovr_col[2] == 3'h1
      |=> multipurpose_pin_function[8 +: 4] == 4'(slfm_pkg::SLFM_FN_AUDIO))
    else $error("override not applied");

  read_status_a: assert property (rd && addr == slfm_pkg::REG_STATUS ##1 1'b1
      |-> rdata[2:0] == $past(st_r.fset) ##1 rdata == 32'h0 || $past(rd))
    else $error("status read wrong");

  // Capture flag, single-strap port enable, reserved codes, fixed routes and the idle read bus
  captured_flag_a: assert property (release_w |=> straps_captured)
    else $error("capture flag not set");

  single_strap_a: assert property (release_w
      && (st_r.samp_dp[0] != st_r.samp_dm[0]) |=> !hs_port_disable[0])
    else $error("single strap disabled a port");

  fixed_reserved_a: assert property (release_w && st_r.samp_fix > 3'h4
      |=> fixed_port_mask == 4'h0 && strap_reserved)
    else $error("reserved fixed code not flagged");

  charge_reserved_a: assert property (release_w && st_r.samp_chg > 3'h4
      |=> charging_port_mask == 4'h0 && strap_reserved)
    else $error("reserved charging code not flagged");

  // Flash and master bus pins ignore the set and any override column; nothing moves them
  flash_fixed_a: assert property (!st_r.ovr_en[18]
      |=> multipurpose_pin_function[72 +: 4] == 4'(slfm_pkg::SLFM_FN_FLASH_SERIAL))
    else $error("flash pin moved");

  master_bus_a: assert property (!st_r.ovr_en[8]
      |=> multipurpose_pin_function[32 +: 4] == 4'(slfm_pkg::SLFM_FN_MASTER_TWOWIRE))
    else $error("master bus pin moved");

  rdata_idle_a: assert property (!rd |=> rdata == 32'h0)
    else $error("read data without strobe");
endmodule

`default_nettype wire

// ### slfm_strap_board.sv
// Board model: strap resistors and the reset sources seen by the strap latch
`default_nettype none

module slfm_strap_board (
  input  wire logic       sys_clk,
  input  wire logic       por_req,
  input  wire logic       ext_req,
  input  wire logic [3:0] dp_cfg,
  input  wire logic [3:0] dm_cfg,
  input  wire logic [2:0] fix_cfg,
  input  wire logic [2:0] chg_cfg,
  input  wire logic [2:0] s1_cfg,
  input  wire logic [2:0] s2_cfg,
  output var  logic       por_active,
  output var  logic       ext_reset_b,
  output var  logic [3:0] dplus_port_disable_strap,
  output var  logic [3:0] dminus_port_disable_strap,
  output var  logic [2:0] fixed_device_strap,
  output var  logic [2:0] charging_ports_strap,
  output var  logic [2:0] function_set_strap1,
  output var  logic [2:0] function_set_strap2,
  output var  logic [2:0] function_set_strap3
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] hold_r = 4'h0;
  logic [7:0] noise_r = 8'h5a;

  initial begin
    por_active = 1'b1;
    ext_reset_b = 1'b1;
    {dplus_port_disable_strap, dminus_port_disable_strap} = 8'h00;
    {fixed_device_strap, charging_ports_strap} = 6'h00;
    {function_set_strap1, function_set_strap2, function_set_strap3} = 9'h000;
  end

  always @(posedge sys_clk) begin
    por_active <= por_req;
    ext_reset_b <= !ext_req;
    noise_r <= noise_r + 8'h35;
    hold_r <= (por_req || ext_req) ? 4'h8 : ((hold_r != 4'h0) ? hold_r - 4'h1 : 4'h0);
    // Third set strap floats, so it wanders every cycle
    function_set_strap3 <= noise_r[2:0];
    if (por_req || ext_req || hold_r != 4'h0) begin
      dplus_port_disable_strap <= dp_cfg;
      dminus_port_disable_strap <= dm_cfg;
      fixed_device_strap <= fix_cfg;
      charging_ports_strap <= chg_cfg;
      // Illegal set pairs only when the bench commands one
      function_set_strap1 <= s1_cfg;
      function_set_strap2 <= s2_cfg;
    end else begin
      // After the hold time the pins carry other traffic
      dplus_port_disable_strap <= ~dp_cfg ^ noise_r[3:0];
      dminus_port_disable_strap <= ~dm_cfg ^ noise_r[7:4];
      fixed_device_strap <= noise_r[2:0];
      charging_ports_strap <= noise_r[5:3];
      function_set_strap1 <= ~s1_cfg;
      function_set_strap2 <= noise_r[7:5];
    end
  end
endmodule

`default_nettype wire

// ### slfm_strap_mux_tb.sv
// Self-checking bench for the strap latch and function mux
`default_nettype none

module slfm_strap_mux_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        por_req = 1'b1;
  logic        ext_req = 1'b0;
  logic [3:0]  dp_cfg = 4'h0, dm_cfg = 4'h0;
  logic [2:0]  fix_cfg = 3'h0, chg_cfg = 3'h0, s1_cfg = 3'h0, s2_cfg = 3'h0;
  wire logic   por_active, ext_reset_b;
  wire logic [3:0] dplus_port_disable_strap, dminus_port_disable_strap;
  wire logic [2:0] fixed_device_strap, charging_ports_strap;
  wire logic [2:0] function_set_strap1, function_set_strap2, function_set_strap3;
  logic [31:0]  rdata;
  logic [3:0]   hs_port_disable, ss_port_disable, fixed_port_mask, charging_port_mask;
  logic [2:0]   function_set;
  logic         strap_reserved, straps_captured;
  logic [119:0] multipurpose_pin_function;
  logic [3:0]   e_hs = 4'h0, e_fix = 4'h0, e_chg = 4'h0;
  logic [2:0]   e_set = 3'h0;
  logic         e_rsv = 1'b0, e_cap = 1'b0;
  int           err_total = 0;
  int           samples_checked = 0;

  slfm_strap_board board (.sys_clk, .por_req, .ext_req, .dp_cfg, .dm_cfg, .fix_cfg,
    .chg_cfg, .s1_cfg, .s2_cfg, .por_active, .ext_reset_b, .dplus_port_disable_strap,
    .dminus_port_disable_strap, .fixed_device_strap, .charging_ports_strap,
    .function_set_strap1, .function_set_strap2, .function_set_strap3);

  slfm_strap_mux uut (.sys_clk, .rst_b, .por_active, .ext_reset_b,
    .dplus_port_disable_strap, .dminus_port_disable_strap, .fixed_device_strap,
    .charging_ports_strap, .function_set_strap1, .function_set_strap2,
    .function_set_strap3, .addr, .wdata, .wr, .rd, .rdata, .hs_port_disable,
    .ss_port_disable, .fixed_port_mask, .charging_port_mask, .function_set,
    .strap_reserved, .straps_captured, .multipurpose_pin_function);

  always #50 sys_clk = ~sys_clk;

  // Expected function code of pin p for set index s (0..4)
  function automatic logic [3:0] exp_fn(input int s, input int p);
    case (p)
      2:           return (s == 2) ? 4'h3 : 4'h0;
      3:           return (s == 1) ? 4'h2 : ((s == 2) ? 4'h3 : 4'h0);
      4, 5, 6, 7:  return (s == 0) ? 4'h1 : ((s == 1) ? 4'h2 : ((s == 2) ? 4'h3 : 4'h0));
      8, 9:        return (s == 0) ? 4'h1 : 4'h4;
      10, 11:      return 4'h5;
      12, 13, 16:  return 4'h6;
      15, 17, 18:  return 4'h7;
      19, 26:      return (s == 3) ? 4'h0 : 4'h8;
      20, 21, 22, 23, 24, 25: return 4'h9;
      27:          return (s == 1) ? 4'ha : 4'h0;
      28:          return (s == 2) ? 4'h3 : 4'h0;
      default:     return 4'h0;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_outputs();
    chk(hs_port_disable, e_hs);
    chk(ss_port_disable, e_hs);
    chk(fixed_port_mask, e_fix);
    chk(charging_port_mask, e_chg);
    chk(function_set, e_set);
    chk(strap_reserved, e_rsv);
    chk(straps_captured, e_cap);
    for (int p = 0; p < 30; p++) begin
      chk(multipurpose_pin_function[4*p+:4], exp_fn(e_set, p + 2));
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge sys_clk);
    #1 chk(rdata, 32'h0);
  endtask

  // Straps set inside a device reset, then released and compared
  task automatic apply(input int dp, input int dm, input int fx, input int cg,
                       input int s1, input int s2, input bit use_por);
    @(posedge sys_clk);
    dp_cfg <= dp[3:0];
    dm_cfg <= dm[3:0];
    fix_cfg <= fx[2:0];
    chg_cfg <= cg[2:0];
    s1_cfg <= s1[2:0];
    s2_cfg <= s2[2:0];
    if (use_por) por_req <= 1'b1;
    else ext_req <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 chk_outputs();
    @(posedge sys_clk);
    por_req <= 1'b0;
    ext_req <= 1'b0;
    e_hs = dp[3:0] & dm[3:0];
    e_fix = (fx <= 4) ? 4'((1 << fx) - 1) : 4'h0;
    e_chg = (cg <= 4) ? 4'((1 << cg) - 1) : 4'h0;
    e_set = (s2 == 0 && s1 <= 4) ? s1[2:0] : 3'h0;
    e_rsv = (fx > 4) || (cg > 4) || (s2 != 0) || (s1 > 4);
    e_cap = 1'b1;
    repeat (12) @(posedge sys_clk);
    #1 chk_outputs();
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #(20000 * 100);
    err_total++;
    summarize();
  end

  initial begin
    int dp, dm, fx, cg, s1;
    logic [31:0] d;
    void'($urandom(32'h60991484));
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      dp = $urandom % 16;
      dm = (i < 2) ? dp : $urandom % 16;
      fx = (i < 5) ? i : $urandom % 5;
      cg = (i < 5) ? 4 - i : $urandom % 5;
      s1 = (i < 5) ? i : $urandom % 5;
      apply(dp, dm, fx, cg, s1, 0, i[0]);
    end
    apply(15, 0, 5, 2, 1, 0, 0);
    apply(3, 3, 1, 7, 2, 1, 1);
    rd_reg(slfm_pkg::REG_STATUS, d);
    chk(d, {26'h0, 1'b0, 1'b1, e_rsv, e_set});
    rd_reg(slfm_pkg::REG_PORTS, d);
    chk(d, {20'h0, e_chg, e_fix, e_hs});
    rd_reg(8'h0c, d);
    chk(d, 32'h0);
    // Pin 4 moved to the audio column by override
    wr_reg(slfm_pkg::REG_PINSEL_0 + 8'h08, 32'h1);
    wr_reg(slfm_pkg::REG_OVR_EN, 32'h4);
    repeat (3) @(posedge sys_clk);
    #1 chk(multipurpose_pin_function[11:8], 4'h2);
    chk(multipurpose_pin_function[15:12], exp_fn(e_set, 5));
    rd_reg(slfm_pkg::REG_PINSEL_0 + 8'h08, d);
    chk(d, 32'h201);
    rd_reg(slfm_pkg::REG_OVR_EN, d);
    chk(d, 32'h4);
    summarize();
  end
endmodule

`default_nettype wire
